// ==== abr_pkg.sv ====
// constants and state types shared by the burst ram slave and its buffer
// assumes a single 200 MHz clock and a 32-bit data path
package abr_pkg;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int ADDR_W = 12;      // 4 kB window, upper bits ignored
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int ID_W = 4;
  localparam int LEN_W = 8;
  localparam int SIZE_W = 3;
  localparam int DEPTH = 1024;     // words of DATA_W
  localparam int IDX_W = 10;
  localparam int WORD_LSB = 2;     // byte address bits below the word
  localparam int LANE_W = 8;
  localparam int RBUF_W = ID_W + DATA_W + 1;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;

  typedef enum logic [1:0] {WR_IDLE, WR_DATA, WR_RESP} abr_wr_state_t;
  typedef enum logic {RD_IDLE, RD_BURST} abr_rd_state_t;

endpackage

// ==== abr_skid_buf.sv ====
// two-entry buffer on the read data path
// assumes source and sink share i_mclk; outputs come straight from flops
module abr_skid_buf
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  input wire logic [abr_pkg::RBUF_W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [abr_pkg::RBUF_W-1:0] o_out_data,
  input wire logic i_out_ready
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic skid_valid;
  logic [abr_pkg::RBUF_W-1:0] skid_data;
  logic in_take;
  logic out_take;
  logic main_free;

  assign in_take = i_in_valid && o_in_ready;
  assign out_take = o_out_valid && i_out_ready;
  // main register is free when empty or being drained this cycle
  assign main_free = !o_out_valid || i_out_ready;

  // in_ready is registered so the source never sees a combinational path
  // from the sink; the skid entry absorbs the one word in flight
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
      o_in_ready <= 1'b1;
    end
    else
    begin
      if (main_free)
      begin
        if (skid_valid)
        begin
          o_out_data <= skid_data;
          o_out_valid <= 1'b1;
          skid_valid <= in_take;
          skid_data <= i_in_data;
          o_in_ready <= !in_take;
        end
        else
        begin
          o_out_data <= i_in_data;
          o_out_valid <= in_take;
          o_in_ready <= 1'b1;
        end
      end
      else if (in_take)
      begin
        skid_valid <= 1'b1;
        skid_data <= i_in_data;
        o_in_ready <= 1'b0;
      end
    end
  end

endmodule

// ==== abr_ram_slave.sv ====
// burst slave: turns write and read bursts into accesses on a simple
// dual-port word memory held inside this module
// assumes the master drives every input from logic on i_mclk
module abr_ram_slave
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [abr_pkg::ID_W-1:0] i_awid,
  input wire logic [abr_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [abr_pkg::LEN_W-1:0] i_awlen,
  input wire logic [abr_pkg::SIZE_W-1:0] i_awsize,
  input wire logic [1:0] i_awburst,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [abr_pkg::DATA_W-1:0] i_wdata,
  input wire logic [abr_pkg::STRB_W-1:0] i_wstrb,
  input wire logic i_wlast,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [abr_pkg::ID_W-1:0] o_bid,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [abr_pkg::ID_W-1:0] i_arid,
  input wire logic [abr_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [abr_pkg::LEN_W-1:0] i_arlen,
  input wire logic [abr_pkg::SIZE_W-1:0] i_arsize,
  input wire logic [1:0] i_arburst,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [abr_pkg::ID_W-1:0] o_rid,
  output logic [abr_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rlast
);

  // ****************************************************************
  // address generator
  // ****************************************************************
  // next byte address of a burst; the wrap mask is the region size less one,
  // ((len+1) << size) - 1, so the start may sit anywhere in the region
  function automatic logic [abr_pkg::ADDR_W-1:0] abr_next_addr
  (
    input logic [abr_pkg::ADDR_W-1:0] addr,
    input logic [abr_pkg::SIZE_W-1:0] size,
    input logic [abr_pkg::LEN_W-1:0] len,
    input logic [1:0] burst
  );
    logic [abr_pkg::ADDR_W-1:0] step;
    logic [abr_pkg::ADDR_W-1:0] mask;
    logic [abr_pkg::ADDR_W-1:0] inc;
    logic [abr_pkg::ADDR_W-1:0] res;
    step = abr_pkg::ADDR_W'(1) << size;
    // align first so narrow lanes rotate with the byte address
    inc = (addr & ~(step - abr_pkg::ADDR_W'(1))) + step;
    mask = ((abr_pkg::ADDR_W'(len) + abr_pkg::ADDR_W'(1)) << size)
      - abr_pkg::ADDR_W'(1);
    if (burst == abr_pkg::BURST_WRAP)
      res = (addr & ~mask) | (inc & mask);
    else if (burst == abr_pkg::BURST_INCR)
      res = inc;
    else
      res = addr;
    return res;
  endfunction

  // ****************************************************************
  // write side state
  // ****************************************************************
  abr_pkg::abr_wr_state_t wr_state;
  logic [abr_pkg::ADDR_W-1:0] wr_addr;
  logic [abr_pkg::LEN_W-1:0] wr_len;
  logic [abr_pkg::LEN_W-1:0] wr_cnt;
  logic [abr_pkg::SIZE_W-1:0] wr_size;
  logic [1:0] wr_burst;
  logic aw_take;
  logic w_take;
  logic w_final;
  logic b_take;
  logic [abr_pkg::IDX_W-1:0] wr_idx;
  logic [abr_pkg::ADDR_W-1:0] next_wr_addr;

  // handshake decode for the write channels
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  // the beat count, not the master's last flag, closes the burst
  assign w_final = (wr_cnt == wr_len);
  assign b_take = o_bvalid && i_bready;
  // only bits above the word lanes select the word
  assign wr_idx = wr_addr[abr_pkg::ADDR_W-1:abr_pkg::WORD_LSB];
  assign next_wr_addr = abr_next_addr(wr_addr, wr_size, wr_len, wr_burst);

  // write state machine: address, data beats, one response
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_state <= abr_pkg::WR_IDLE;
      o_awready <= 1'b1;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bid <= '0;
      o_bresp <= abr_pkg::RESP_OKAY;
      wr_addr <= '0;
      wr_len <= '0;
      wr_cnt <= '0;
      wr_size <= '0;
      wr_burst <= '0;
    end
    else
    begin
      case (wr_state)
        abr_pkg::WR_IDLE:
        begin
          if (aw_take)
          begin
            wr_addr <= i_awaddr;
            wr_len <= i_awlen;
            wr_size <= i_awsize;
            wr_burst <= i_awburst;
            o_bid <= i_awid;
            wr_cnt <= abr_pkg::LEN_ZERO;
            o_awready <= 1'b0;
            o_wready <= 1'b1;
            wr_state <= abr_pkg::WR_DATA;
          end
        end
        abr_pkg::WR_DATA:
        begin
          if (w_take)
          begin
            wr_addr <= next_wr_addr;
            wr_cnt <= wr_cnt + 8'h01;
            if (w_final)
            begin
              o_wready <= 1'b0;
              o_bvalid <= 1'b1;
              o_bresp <= abr_pkg::RESP_OKAY;
              wr_state <= abr_pkg::WR_RESP;
            end
          end
        end
        abr_pkg::WR_RESP:
        begin
          if (b_take)
          begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            wr_state <= abr_pkg::WR_IDLE;
          end
        end
        default:
        begin
          wr_state <= abr_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // read side state
  // ****************************************************************
  abr_pkg::abr_rd_state_t rd_state;
  logic [abr_pkg::ADDR_W-1:0] rd_addr;
  logic [abr_pkg::LEN_W-1:0] rd_len;
  logic [abr_pkg::LEN_W-1:0] rd_cnt;
  logic [abr_pkg::SIZE_W-1:0] rd_size;
  logic [1:0] rd_burst;
  logic [abr_pkg::ID_W-1:0] rd_id;
  logic ar_take;
  logic rd_push;
  logic rd_final;
  logic buf_ready;
  logic [abr_pkg::IDX_W-1:0] rd_idx;
  logic [abr_pkg::DATA_W-1:0] rd_word;
  logic [abr_pkg::RBUF_W-1:0] buf_in;
  logic [abr_pkg::RBUF_W-1:0] buf_out;
  logic [abr_pkg::ADDR_W-1:0] next_rd_addr;

  // one buffer push per beat, stalled by the buffer when it is full
  assign ar_take = i_arvalid && o_arready;
  assign rd_push = (rd_state == abr_pkg::RD_BURST) && buf_ready;
  assign rd_final = (rd_cnt == rd_len);
  assign rd_idx = rd_addr[abr_pkg::ADDR_W-1:abr_pkg::WORD_LSB];
  assign buf_in = {rd_id, rd_word, rd_final};
  assign next_rd_addr = abr_next_addr(rd_addr, rd_size, rd_len, rd_burst);

  // read state machine: take an address, push len+1 words
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_state <= abr_pkg::RD_IDLE;
      o_arready <= 1'b1;
      rd_addr <= '0;
      rd_len <= '0;
      rd_cnt <= '0;
      rd_size <= '0;
      rd_burst <= '0;
      rd_id <= '0;
    end
    else
    begin
      case (rd_state)
        abr_pkg::RD_IDLE:
        begin
          if (ar_take)
          begin
            rd_addr <= i_araddr;
            rd_len <= i_arlen;
            rd_size <= i_arsize;
            rd_burst <= i_arburst;
            rd_id <= i_arid;
            rd_cnt <= abr_pkg::LEN_ZERO;
            o_arready <= 1'b0;
            rd_state <= abr_pkg::RD_BURST;
          end
        end
        abr_pkg::RD_BURST:
        begin
          if (rd_push)
          begin
            rd_addr <= next_rd_addr;
            rd_cnt <= rd_cnt + 8'h01;
            if (rd_final)
            begin
              o_arready <= 1'b1;
              rd_state <= abr_pkg::RD_IDLE;
            end
          end
        end
        default:
        begin
          rd_state <= abr_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // memory, one array per byte lane
  // ****************************************************************
  // a lane array each keeps every byte enable a separate writer; the
  // read is asynchronous so a word reaches the buffer in its push cycle
  for (genvar g = 0; g < abr_pkg::STRB_W; g++)
  begin : g_lane
    logic [abr_pkg::LANE_W-1:0] mem [abr_pkg::DEPTH];
    logic lane_we;
    // a strobe on an accepted beat writes only its own byte
    assign lane_we = w_take && i_wstrb[g];
    always_ff @(posedge i_mclk)
    begin
      if (lane_we)
        mem[wr_idx] <= i_wdata[g*abr_pkg::LANE_W +: abr_pkg::LANE_W];
    end
    // the full word goes back; the master picks its own lanes
    assign rd_word[g*abr_pkg::LANE_W +: abr_pkg::LANE_W] = mem[rd_idx];
  end

  // ****************************************************************
  // read data buffer and response
  // ****************************************************************
  // rvalid and data come from the buffer flops; a ready seen in the
  // valid cycle retires that beat at once
  abr_skid_buf u_rbuf
  (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_in_valid(rd_state == abr_pkg::RD_BURST),
    .i_in_data(buf_in),
    .o_in_ready(buf_ready),
    .o_out_valid(o_rvalid),
    .o_out_data(buf_out),
    .i_out_ready(i_rready)
  );

  // fields of the buffered beat
  assign o_rid = buf_out[abr_pkg::RBUF_W-1 -: abr_pkg::ID_W];
  assign o_rdata = buf_out[abr_pkg::DATA_W:1];
  assign o_rlast = buf_out[0];

  // read response is always okay; kept in a flop like every output
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rresp <= abr_pkg::RESP_OKAY;
    else
      o_rresp <= abr_pkg::RESP_OKAY;
  end

endmodule

// ==== abr_ram_slave_sva.sv ====
// concurrent checks on the burst slave handshakes
// assumes it is bound into abr_ram_slave and sees its ports only
module abr_ram_slave_sva
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [abr_pkg::DATA_W-1:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rlast
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // ****************************************************************
  // write channels
  // ****************************************************************
  // address taken closes the address port and opens the data port
  a_aw_opens_w: assert property (
    i_awvalid && o_awready |=> o_wready && !o_awready)
    else $error("data port not opened after address");
  a_w_closed_idle: assert property (o_awready |-> !o_wready)
    else $error("data port open with no address");
  a_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("response dropped before accept");
  a_b_reopens: assert property (
    o_bvalid && i_bready |=> !o_bvalid && o_awready)
    else $error("address port not reopened after response");
  a_b_okay: assert property (
    o_bvalid |-> o_bresp == abr_pkg::RESP_OKAY)
    else $error("write response not okay");

  // ****************************************************************
  // read channels
  // ****************************************************************
  // first beat two cycles after the address, then no gap inside a burst
  a_ar_first_beat: assert property (
    i_arvalid && o_arready |=> !o_arready ##1 o_rvalid)
    else $error("first read beat late");
  a_r_stall_hold: assert property (
    o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rlast))
    else $error("read beat changed while stalled");
  a_r_no_gap: assert property (o_rvalid && !o_rlast |=> o_rvalid)
    else $error("gap inside read burst");
  a_r_okay: assert property (
    o_rvalid |-> o_rresp == abr_pkg::RESP_OKAY)
    else $error("read response not okay");
endmodule

// ==== abr_mst_model.sv ====
// far-side master model: paces read beats and response acceptance
// assumes the bench drives the request channels itself
module abr_mst_model
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_slow,
  output logic o_rready,
  output logic o_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace;

  // slow mode takes one beat in four, so the buffer must fill and hold
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pace <= 2'h0;
      o_rready <= 1'b0;
      o_bready <= 1'b0;
    end
    else
    begin
      pace <= pace + 2'h1;
      o_rready <= !i_slow || (pace == 2'h3);
      o_bready <= !i_slow || pace[0];
    end
  end
endmodule

// ==== abr_ram_slave_tb.sv ====
// bench for the burst slave: each burst is written, then read back
// assumes abr_pkg, the slave, the master model and the checker exist
module abr_ram_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] len;
    logic [2:0] size;
    logic [1:0] burst;
    logic [3:0] strb;
    logic slow;
  } abr_row_t;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, slow = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_wlast = 1'b0, i_arvalid = 1'b0;
  logic [3:0] i_awid = '0, i_arid = '0, i_wstrb = '0, o_bid, o_rid;
  logic [11:0] i_awaddr = '0, i_araddr = '0;
  logic [7:0] i_awlen = '0, i_arlen = '0;
  logic [2:0] i_awsize = '0, i_arsize = '0;
  logic [1:0] i_awburst = '0, i_arburst = '0, o_bresp, o_rresp;
  logic [31:0] i_wdata = '0, o_rdata;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rlast;
  logic i_bready, i_rready;
  logic [31:0] ref_mem [0:1023];
  int n_fail = 0, check_count = 0, cyc = 0, dseq = 0;
  // wrap rows use only lengths 2, 4, 8, 16 and code 10
  abr_row_t rows [0:9] = '{
    '{12'h000, 8'hFF, 3'h2, 2'h1, 4'hF, 1'b0},
    '{12'h3FC, 8'h00, 3'h2, 2'h1, 4'hF, 1'b1},
    '{12'h004, 8'h03, 3'h2, 2'h2, 4'hF, 1'b0},
    '{12'h10C, 8'h01, 3'h2, 2'h2, 4'h5, 1'b1},
    '{12'h108, 8'h07, 3'h2, 2'h2, 4'hF, 1'b1},
    '{12'h108, 8'h0F, 3'h1, 2'h2, 4'hF, 1'b0},
    '{12'h202, 8'h03, 3'h1, 2'h1, 4'hF, 1'b1},
    '{12'h301, 8'h05, 3'h0, 2'h1, 4'hF, 1'b0},
    '{12'h200, 8'h02, 3'h2, 2'h0, 4'hF, 1'b0}, // fixed burst
    '{12'h0C8, 8'h0F, 3'h2, 2'h2, 4'hE, 1'b1}};

  abr_ram_slave dut_u (.i_mclk, .i_arst_n, .i_awvalid, .o_awready, .i_awid,
    .i_awaddr, .i_awlen, .i_awsize, .i_awburst, .i_wvalid, .o_wready,
    .i_wdata, .i_wstrb, .i_wlast, .o_bvalid, .i_bready, .o_bid, .o_bresp,
    .i_arvalid, .o_arready, .i_arid, .i_araddr, .i_arlen, .i_arsize,
    .i_arburst, .o_rvalid, .i_rready, .o_rid, .o_rdata, .o_rresp, .o_rlast);
  abr_mst_model mst_u (.i_mclk, .i_arst_n, .i_slow(slow),
    .o_rready(i_rready), .o_bready(i_bready));

  // clock and hang guard
  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // reference address step; wrap stays inside the aligned region
  function logic [11:0] next_addr(input abr_row_t r, input logic [11:0] a);
    logic [11:0] mask;
    mask = (({4'h0, r.len} + 12'h1) << r.size) - 12'h1;
    // a fixed burst keeps hitting its start address
    if (r.burst == abr_pkg::BURST_FIXED)
      return a;
    if (r.burst == abr_pkg::BURST_WRAP)
      return (a & ~mask) | ((a + (12'h1 << r.size)) & mask);
    return a + (12'h1 << r.size);
  endfunction

  task wr(input abr_row_t r);
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    a = r.addr;
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_awaddr <= r.addr;
    i_awlen <= r.len;
    i_awsize <= r.size;
    i_awburst <= r.burst;
    i_awid <= r.len[3:0];
    do @(posedge i_mclk); while (!o_awready);
    i_awvalid <= 1'b0;
    for (int i = 0; i <= r.len; i++)
    begin
      d = {dseq[15:0], ~dseq[15:0]};
      dseq++;
      s = r.strb & (((4'h1 << (1 << r.size)) - 4'h1) << a[1:0]);
      i_wvalid <= 1'b1;
      i_wdata <= d;
      i_wstrb <= s;
      i_wlast <= (i == r.len);
      do @(posedge i_mclk); while (!o_wready);
      for (int b = 0; b < 4; b++)
        if (s[b])
          ref_mem[a[11:2]][8*b +: 8] = d[8*b +: 8];
      a = next_addr(r, a);
    end
    i_wvalid <= 1'b0;
    i_wlast <= 1'b0;
    do @(posedge i_mclk); while (!(o_bvalid && i_bready));
    check({o_bid, o_bresp},
      {r.len[3:0], abr_pkg::RESP_OKAY});
  endtask

  task rd(input abr_row_t r);
    logic [11:0] a;
    a = r.addr;
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr <= r.addr;
    i_arlen <= r.len;
    i_arsize <= r.size;
    i_arburst <= r.burst;
    i_arid <= ~r.len[3:0];
    do @(posedge i_mclk); while (!o_arready);
    i_arvalid <= 1'b0;
    for (int i = 0; i <= r.len; i++)
    begin
      do @(posedge i_mclk); while (!(o_rvalid && i_rready));
      check(o_rdata, ref_mem[a[11:2]]);
      check({o_rid, o_rlast, o_rresp},
        {~r.len[3:0], i == r.len, abr_pkg::RESP_OKAY});
      a = next_addr(r, a);
    end
  endtask

  // reset values, the burst table, then data offered with no address
  initial
  begin
    repeat (20) @(posedge i_mclk);
    check({o_awready, o_arready, o_wready, o_bvalid, o_rvalid},
      5'h18);
    i_arst_n <= 1'b1;
    foreach (rows[k])
    begin
      slow <= rows[k].slow;
      wr(rows[k]);
      rd(rows[k]);
    end
    @(posedge i_mclk);
    i_wvalid <= 1'b1;
    repeat (4)
    begin
      @(posedge i_mclk);
      check(o_wready, 1'b0);
    end
    i_wvalid <= 1'b0;
    // the stray beat would land on the wrap row's start word
    rd(rows[9]);
    print_verdict;
  end
endmodule

bind abr_ram_slave abr_ram_slave_sva chk_u (.i_mclk, .i_arst_n, .i_awvalid,
  .o_awready, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
  .o_arready, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_rlast);
